// ===== core/iout_fault_pkg.sv
// constants shared by the output current fault response block
package iout_fault_pkg;
  localparam int          PAGES          = 2;      // output pages
  localparam logic [7:0]  CMD_OC_RESP    = 8'hE5;  // overcurrent response
  localparam logic [7:0]  CMD_UC_RESP    = 8'hE6;  // undercurrent response
  localparam logic [7:0]  CMD_AVG_OC_LIM = 8'hE7;  // average oc limit
  localparam logic [7:0]  RESP_RESET     = 8'h80;  // shutdown, no retry
  localparam logic [15:0] AVG_LIM_RESET  = 16'hDA00; // 16 A
  localparam int          RESP_MSB       = 7;      // response field 7:6
  localparam int          RESP_LSB       = 6;
  localparam int          RETRY_MSB      = 5;      // retry field 5:3
  localparam int          RETRY_LSB      = 3;
  localparam logic [1:0]  RESP_SHUTDOWN  = 2'h2;   // only used response
  localparam logic [2:0]  RETRY_NONE     = 3'h0;
  localparam logic [2:0]  RETRY_FOREVER  = 3'h7;
  localparam int          EXP_MSB        = 15;     // linear-11 exponent
  localparam int          EXP_LSB        = 11;
  localparam int          SAMPLE_FRAC    = 4;      // sample lsb = 1/16 A
  localparam int          SAMPLE_W       = 16;     // signed sample width
  localparam int          COUNT_W        = 8;      // sample counter width
  localparam int          SUM_W          = 26;     // accumulator width
  localparam logic [7:0]  BLANK_SAMPLES  = 8'h02;  // blanked samples
  localparam int          CLK_HZ         = 10000000;
  localparam int          RETRY_MS       = 70;     // retry interval
  localparam int          RETRY_CYCLES   = CLK_HZ / 1000 * RETRY_MS;
  // per-page fault handling state
  typedef enum logic [2:0]
  {
    ST_RUN  = 3'b001,
    ST_HOLD = 3'b010,
    ST_WAIT = 3'b100
  } fault_state_t;
endpackage

// ===== core/interval_averager.sv
// blanked interval averager comparing the mean current against a limit
`timescale 1ns/1ps
module interval_averager
  import iout_fault_pkg::*;
(
  input  wire logic                       clk_in,      // system clock
  input  wire logic                       reset_in,    // sync reset, high
  input  wire logic                       interval_in, // sensed interval
  input  wire logic                       valid_in,    // sample strobe
  input  wire logic signed [SAMPLE_W-1:0] sample_in,   // current sample
  input  wire logic signed [SAMPLE_W-1:0] limit_in,    // limit, same lsb
  output logic                            over_out     // one-cycle pulse
);
  logic signed [SUM_W-1:0]   sum;          // sum of kept samples
  logic signed [SUM_W-1:0]   next_sum;
  logic        [COUNT_W-1:0] kept;         // kept sample count
  logic        [COUNT_W-1:0] next_kept;
  logic        [COUNT_W-1:0] seen;         // blanked samples so far
  logic        [COUNT_W-1:0] next_seen;
  logic                      active;       // interval seen last cycle
  logic                      next_over;
  logic signed [SUM_W-1:0]   scaled_limit; // limit times kept count

  //////////////////////////////////////////////////////////////////////////
  // accumulate, then compare sum with limit scaled by the count
  always_comb
  begin
    next_sum     = sum;
    next_kept    = kept;
    next_seen    = seen;
    next_over    = 1'b0;
    scaled_limit = SUM_W'(limit_in) * $signed({1'b0, kept});
    if (interval_in && !active)
    begin
      // new interval: restart the average
      next_sum  = '0;
      next_kept = '0;
      // a sample on the opening cycle is the first blanked one
      next_seen = COUNT_W'(valid_in);
    end
    else if (interval_in && valid_in)
    begin
      if (seen < BLANK_SAMPLES)
        next_seen = seen + 1'b1;
      else if (kept != {COUNT_W{1'b1}})
      begin
        next_sum  = sum + SUM_W'(sample_in);
        next_kept = kept + 1'b1;
      end
    end
    else if (!interval_in && active && kept != '0)
      next_over = (sum > scaled_limit);
  end

  // register stage
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sum      <= '0;
      kept     <= '0;
      seen     <= '0;
      active   <= 1'b0;
      over_out <= 1'b0;
    end
    else
    begin
      sum      <= next_sum;
      kept     <= next_kept;
      seen     <= next_seen;
      active   <= interval_in;
      over_out <= next_over;
    end
  end
endmodule // interval_averager

// ===== core/iout_fault_response.sv
// paged output current fault response with retry and alert
`timescale 1ns/1ps
module iout_fault_response
  import iout_fault_pkg::*;
#(
  parameter int RETRY_COUNT = RETRY_CYCLES     // retry interval, cycles
)
(
  input  wire logic                          SYS_CLK_IN,       // clock
  input  wire logic                          RESET_IN,         // sync reset
  input  wire logic                          PAGE_IN,          // page
  input  wire logic [7:0]                    CMD_CODE_IN,      // command
  input  wire logic                          WRITE_IN,         // write
  input  wire logic                          READ_IN,          // read
  input  wire logic [15:0]                   WRITE_DATA_IN,    // data
  input  wire logic                          CLEAR_FAULTS_IN,  // clear
  input  wire logic [iout_fault_pkg::PAGES-1:0] ON_CMD_IN,     // output on
  input  wire logic [iout_fault_pkg::PAGES-1:0] OTHER_FAULT_IN,// other
  input  wire logic [iout_fault_pkg::PAGES-1:0] PEAK_OC_IN,    // peak oc
  input  wire logic [iout_fault_pkg::PAGES-1:0] UC_IN,         // uc limit
  input  wire logic [iout_fault_pkg::PAGES-1:0] UP_SLOPE_IN,   // slope
  input  wire logic [iout_fault_pkg::PAGES-1:0] ON_INTERVAL_IN,// D phase
  input  wire logic [iout_fault_pkg::PAGES-1:0] SAMPLE_VALID_IN,// strobe
  input  wire logic [iout_fault_pkg::SAMPLE_W-1:0] SAMPLE0_IN, // page 0
  input  wire logic [iout_fault_pkg::SAMPLE_W-1:0] SAMPLE1_IN, // page 1
  output logic      [15:0]                   READ_DATA_OUT,    // readback
  output logic [iout_fault_pkg::PAGES-1:0]   OUTPUT_EN_OUT,    // enable
  output logic [iout_fault_pkg::PAGES-1:0]   OC_FLAG_OUT,      // oc flag
  output logic [iout_fault_pkg::PAGES-1:0]   UC_FLAG_OUT,      // uc flag
  output logic                               ALERT_LINE_N_OUT  // alert
);
  logic [7:0]         oc_cfg      [PAGES];  // overcurrent_response_cfg
  logic [7:0]         uc_cfg      [PAGES];  // undercurrent_response_cfg
  logic [15:0]        avg_lim     [PAGES];  // average_overcurrent_limit
  logic [7:0]         next_oc_cfg [PAGES];
  logic [7:0]         next_uc_cfg [PAGES];
  logic [15:0]        next_avg_lim[PAGES];
  logic [15:0]        next_read;            // readback value
  fault_state_t       state       [PAGES];  // response state
  fault_state_t       next_state  [PAGES];
  logic [31:0]        timer       [PAGES];  // retry interval count
  logic [31:0]        next_timer  [PAGES];
  logic [PAGES-1:0]   next_en;
  logic [PAGES-1:0]   next_oc;
  logic [PAGES-1:0]   next_uc;
  logic [PAGES-1:0]   avg_over;             // average oc pulses
  logic signed [SAMPLE_W-1:0] lim_fixed[PAGES]; // limit in sample lsb
  logic [SAMPLE_W-1:0] samples [PAGES];

  assign samples[0] = SAMPLE0_IN;
  assign samples[1] = SAMPLE1_IN;

  function automatic logic signed [SAMPLE_W-1:0] lin11(
    input logic [15:0] v
  );
    logic signed [5:0]  sh;
    logic signed [31:0] y;
    sh = 6'($signed(v[EXP_MSB:EXP_LSB])) + 6'(SAMPLE_FRAC);
    y  = 32'($signed(v[EXP_LSB-1:0]));
    if (sh >= 0)
      y = y <<< sh;
    else
      y = y >>> (-sh);
    return y[SAMPLE_W-1:0];
  endfunction

  // retry policy: 1 only for the shutdown response with continuous retry
  function automatic logic retry_on(input logic [7:0] cfg);
    return cfg[RESP_MSB:RESP_LSB] == RESP_SHUTDOWN &&
           cfg[RETRY_MSB:RETRY_LSB] == RETRY_FOREVER;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // averagers, one per page, watching the interval for the slope
  // limits in sample units
  always_comb
  begin
    for (int p = 0; p < PAGES; p++)
      lim_fixed[p] = lin11(avg_lim[p]);
  end
  genvar g;
  generate
    for (g = 0; g < PAGES; g++)
    begin : g_avg
      interval_averager u_avg (
        .clk_in      (SYS_CLK_IN),
        .interval_in (UP_SLOPE_IN[g] ? ON_INTERVAL_IN[g]
                                     : !ON_INTERVAL_IN[g]),
        .reset_in    (RESET_IN),
        .valid_in    (SAMPLE_VALID_IN[g]),
        .sample_in   ($signed(samples[g])),
        .limit_in    (lim_fixed[g]),
        .over_out    (avg_over[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // register writes and readback
  always_comb
  begin
    next_oc_cfg  = oc_cfg;
    next_uc_cfg  = uc_cfg;
    next_avg_lim = avg_lim;
    next_read    = READ_DATA_OUT;
    if (WRITE_IN)
    begin
      case (CMD_CODE_IN)
        CMD_OC_RESP:    next_oc_cfg[PAGE_IN]  = WRITE_DATA_IN[7:0];
        CMD_UC_RESP:    next_uc_cfg[PAGE_IN]  = WRITE_DATA_IN[7:0];
        CMD_AVG_OC_LIM: next_avg_lim[PAGE_IN] = WRITE_DATA_IN;
        default:        next_read             = READ_DATA_OUT;
      endcase
    end
    if (READ_IN)
    begin
      case (CMD_CODE_IN)
        CMD_OC_RESP:    next_read = {8'h00, oc_cfg[PAGE_IN]};
        CMD_UC_RESP:    next_read = {8'h00, uc_cfg[PAGE_IN]};
        CMD_AVG_OC_LIM: next_read = avg_lim[PAGE_IN];
        default:        next_read = 16'h0000;   // unknown command
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault detection, flags and shutdown sequencing per page
  always_comb
  begin
    logic oc_evt;
    logic uc_evt;
    oc_evt     = 1'b0;
    uc_evt     = 1'b0;
    next_state = state;
    next_timer = timer;
    next_oc    = OC_FLAG_OUT;
    next_uc    = UC_FLAG_OUT;
    next_en    = OUTPUT_EN_OUT;
    for (int p = 0; p < PAGES; p++)
    begin
      oc_evt = OUTPUT_EN_OUT[p] && (PEAK_OC_IN[p] || avg_over[p]);
      uc_evt = OUTPUT_EN_OUT[p] && UC_IN[p];
      if (CLEAR_FAULTS_IN)
      begin
        next_oc[p] = 1'b0;
        next_uc[p] = 1'b0;
      end
      if (oc_evt)
        next_oc[p] = 1'b1;
      if (uc_evt)
        next_uc[p] = 1'b1;
      case (state[p])
        ST_RUN:
        begin
          if (oc_evt || uc_evt)
          begin
            next_en[p]    = 1'b0;
            next_timer[p] = '0;
            if (oc_evt ? retry_on(oc_cfg[p]) : retry_on(uc_cfg[p]))
              next_state[p] = ST_WAIT;
            else
              next_state[p] = ST_HOLD;
          end
          else
            next_en[p] = ON_CMD_IN[p];
        end
        ST_HOLD:
        begin
          next_en[p] = 1'b0;
          if (CLEAR_FAULTS_IN)
            next_state[p] = ST_RUN;  // released once faults cleared
        end
        ST_WAIT:
        begin
          next_en[p] = 1'b0;
          // stop on off command or fault
          if (!ON_CMD_IN[p] || OTHER_FAULT_IN[p])
            next_state[p] = ST_HOLD;
          else if (timer[p] >= 32'(RETRY_COUNT - 1))
          begin
            next_state[p] = ST_RUN;
            next_en[p]    = 1'b1;
          end
          else
            next_timer[p] = timer[p] + 32'd1;
        end
        default:
        begin
          next_state[p] = ST_HOLD;
          next_en[p]    = 1'b0;
        end
      endcase
    end
  end

  // register stage for configuration, state and outputs
  always_ff @(posedge SYS_CLK_IN)
  begin
    if (RESET_IN)
    begin
      for (int p = 0; p < PAGES; p++)
      begin
        oc_cfg[p]  <= RESP_RESET;
        uc_cfg[p]  <= RESP_RESET;
        avg_lim[p] <= AVG_LIM_RESET;
        state[p]   <= ST_RUN;
        timer[p]   <= '0;
      end
      READ_DATA_OUT    <= 16'h0000;
      OUTPUT_EN_OUT    <= '0;
      OC_FLAG_OUT      <= '0;
      UC_FLAG_OUT      <= '0;
      ALERT_LINE_N_OUT <= 1'b1;
    end
    else
    begin
      oc_cfg           <= next_oc_cfg;
      uc_cfg           <= next_uc_cfg;
      avg_lim          <= next_avg_lim;
      state            <= next_state;
      timer            <= next_timer;
      READ_DATA_OUT    <= next_read;
      OUTPUT_EN_OUT    <= next_en;
      OC_FLAG_OUT      <= next_oc;
      UC_FLAG_OUT      <= next_uc;
      ALERT_LINE_N_OUT <= ~(|next_oc | |next_uc);
    end
  end
endmodule // iout_fault_response

// ===== test/stage_model.sv
// power stage model giving per-interval current samples
`timescale 1ns/1ps
module stage_model
  import iout_fault_pkg::*;
(
  input  wire logic                clk_in,              // system clock
  input  wire logic [SAMPLE_W-1:0] on_lvl_in,           // current in D
  input  wire logic [SAMPLE_W-1:0] off_lvl_in,          // current in 1-D
  input  wire logic [SAMPLE_W-1:0] spike_in,            // switching ring
  output logic                     interval_out = 1'h0, // high during D
  output logic                     valid_out = 1'h0,    // sample strobe
  output logic [SAMPLE_W-1:0]      sample_out = 16'h0   // current sample
);
  logic [4:0] phase = 5'h0;  // position in the switching period
  logic [SAMPLE_W-1:0] lvl;  // level of this sample slot
  ////////////////////////////////////////////////////////////////////////
  // ringing in the first two samples of each interval, else steady level
  assign lvl = (phase[3:1] < 3'h2) ? spike_in
             : (phase[4] ? on_lvl_in : off_lvl_in);
  // samples only on every other cycle; data line toggles between them
  always @(posedge clk_in)
  begin
    phase        <= phase + 5'h1;
    interval_out <= phase[4];
    valid_out    <= phase[0];
    sample_out   <= phase[0] ? lvl : ~sample_out;
  end
endmodule // stage_model

// ===== test/iout_fault_chk.sv
// assertion checker for the output current fault response block
`timescale 1ns/1ps
module iout_fault_chk
  import iout_fault_pkg::*;
#(
  parameter int RETRY_COUNT = 20  // retry interval, cycles
)
(
  input wire logic              SYS_CLK_IN,       // clock
  input wire logic              RESET_IN,         // sync reset
  input wire logic              PAGE_IN,          // page
  input wire logic [7:0]        CMD_CODE_IN,      // command
  input wire logic              WRITE_IN,         // write
  input wire logic              READ_IN,          // read
  input wire logic [15:0]       WRITE_DATA_IN,    // data
  input wire logic              CLEAR_FAULTS_IN,  // clear
  input wire logic [PAGES-1:0]  OTHER_FAULT_IN,   // other fault
  input wire logic [PAGES-1:0]  PEAK_OC_IN,       // peak oc
  input wire logic [PAGES-1:0]  UC_IN,            // uc
  input wire logic [15:0]       READ_DATA_OUT,    // readback
  input wire logic [PAGES-1:0]  OUTPUT_EN_OUT,    // enable
  input wire logic [PAGES-1:0]  OC_FLAG_OUT,      // oc flag
  input wire logic [PAGES-1:0]  UC_FLAG_OUT,      // uc flag
  input wire logic              ALERT_LINE_N_OUT  // alert
);
  import iout_fault_pkg::*;
  logic [7:0]  oc_cfg0, next_oc_cfg0;  // copy of page 0 oc config
  logic [31:0] off_cnt, next_off_cnt;  // cycles page 0 stayed off
  ////////////////////////////////////////////////////////////////////////
  // shadow config and off-time counter
  always_comb
  begin
    next_oc_cfg0 = oc_cfg0;
    if (WRITE_IN && !PAGE_IN && CMD_CODE_IN == CMD_OC_RESP)
      next_oc_cfg0 = WRITE_DATA_IN[7:0];
    next_off_cnt = OUTPUT_EN_OUT[0] ? 32'h0 : off_cnt + 32'h1;
  end
  always_ff @(posedge SYS_CLK_IN)
  begin
    oc_cfg0 <= RESET_IN ? RESP_RESET : next_oc_cfg0;
    off_cnt <= RESET_IN ? 32'h0 : next_off_cnt;
  end
  default clocking dc @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);
  ////////////////////////////////////////////////////////////////////////
  chk_oc_shut: assert property (
    OUTPUT_EN_OUT[0] && PEAK_OC_IN[0] |=> !OUTPUT_EN_OUT[0] && OC_FLAG_OUT[0])
    else $error("peak oc did not shut page 0");
  chk_uc_shut: assert property (
    OUTPUT_EN_OUT[0] && UC_IN[0] |=> !OUTPUT_EN_OUT[0] && UC_FLAG_OUT[0])
    else $error("uc did not shut page 0");
  chk_alert_flags: assert property (
    ALERT_LINE_N_OUT == !(|{OC_FLAG_OUT, UC_FLAG_OUT}))
    else $error("alert line disagrees with flags");
  chk_flag_hold: assert property (
    $fell(OC_FLAG_OUT[0]) || $fell(UC_FLAG_OUT[0]) |-> $past(CLEAR_FAULTS_IN))
    else $error("flag dropped without clear");
  chk_hold_off: assert property (
    OC_FLAG_OUT[0] && !OUTPUT_EN_OUT[0] && oc_cfg0[7:3] != 5'h17
    && !CLEAR_FAULTS_IN |=> !OUTPUT_EN_OUT[0])
    else $error("output restarted without retry policy");
  chk_retry_gap: assert property (
    $rose(OUTPUT_EN_OUT[0]) && (OC_FLAG_OUT[0] || UC_FLAG_OUT[0])
    |-> off_cnt >= RETRY_COUNT)
    else $error("restart came before the retry interval");
  chk_other_stop: assert property (
    (OC_FLAG_OUT[0] || UC_FLAG_OUT[0]) && !OUTPUT_EN_OUT[0]
    && OTHER_FAULT_IN[0] && !CLEAR_FAULTS_IN |=> !OUTPUT_EN_OUT[0])
    else $error("retry went on during another fault");
  chk_reset_out: assert property (
    $fell(RESET_IN) |-> OUTPUT_EN_OUT == 2'h0 && OC_FLAG_OUT == 2'h0
    && UC_FLAG_OUT == 2'h0 && ALERT_LINE_N_OUT && READ_DATA_OUT == 16'h0)
    else $error("outputs wrong after reset");
  chk_cfg_read: assert property (
    READ_IN && !WRITE_IN && !PAGE_IN && CMD_CODE_IN == CMD_OC_RESP
    |=> READ_DATA_OUT[7:3] == oc_cfg0[7:3])
    else $error("oc config readback wrong");
endmodule // iout_fault_chk
bind iout_fault_response iout_fault_chk #(.RETRY_COUNT(RETRY_COUNT)) chk_i (
  .SYS_CLK_IN(SYS_CLK_IN), .RESET_IN(RESET_IN), .PAGE_IN(PAGE_IN),
  .CMD_CODE_IN(CMD_CODE_IN), .WRITE_IN(WRITE_IN), .READ_IN(READ_IN),
  .WRITE_DATA_IN(WRITE_DATA_IN), .CLEAR_FAULTS_IN(CLEAR_FAULTS_IN),
  .OTHER_FAULT_IN(OTHER_FAULT_IN), .PEAK_OC_IN(PEAK_OC_IN), .UC_IN(UC_IN),
  .READ_DATA_OUT(READ_DATA_OUT), .OUTPUT_EN_OUT(OUTPUT_EN_OUT),
  .OC_FLAG_OUT(OC_FLAG_OUT), .UC_FLAG_OUT(UC_FLAG_OUT),
  .ALERT_LINE_N_OUT(ALERT_LINE_N_OUT));

// ===== test/tb_top.sv
// self-checking bench for the output current fault response block
`timescale 1ns/1ps
module tb_top;
  import iout_fault_pkg::*;
  localparam int RC = 20;                 // shortened retry interval
  logic        clk, rst, page, wr, rd, clr, alert_n, pend = 1'h0;
  logic [7:0]  cmd;                       // command code
  logic [15:0] wdata, rdata, s0, s1, on0, off0, spk;
  logic [1:0]  on_cmd, other, peak, uc, up, en, oc_f, uc_f, ival, vld;
  logic [31:0] rv;                        // random word
  logic [15:0] exq[$];                    // expected read results
  logic [7:0]  bad [5] = '{8'h00, 8'h40, 8'hC0, 8'hF8, 8'h90};
  int          failures = 0, checks_done = 0, n;
  ////////////////////////////////////////////////////////////////////////
  iout_fault_response #(.RETRY_COUNT(RC)) DUT (
    .SYS_CLK_IN(clk), .RESET_IN(rst), .PAGE_IN(page), .CMD_CODE_IN(cmd),
    .WRITE_IN(wr), .READ_IN(rd), .WRITE_DATA_IN(wdata),
    .CLEAR_FAULTS_IN(clr), .ON_CMD_IN(on_cmd), .OTHER_FAULT_IN(other),
    .PEAK_OC_IN(peak), .UC_IN(uc), .UP_SLOPE_IN(up), .ON_INTERVAL_IN(ival),
    .SAMPLE_VALID_IN(vld), .SAMPLE0_IN(s0), .SAMPLE1_IN(s1),
    .READ_DATA_OUT(rdata), .OUTPUT_EN_OUT(en), .OC_FLAG_OUT(oc_f),
    .UC_FLAG_OUT(uc_f), .ALERT_LINE_N_OUT(alert_n));
  stage_model P0 (.clk_in(clk), .on_lvl_in(on0), .off_lvl_in(off0),
    .spike_in(spk), .interval_out(ival[0]), .valid_out(vld[0]),
    .sample_out(s0));
  stage_model P1 (.clk_in(clk), .on_lvl_in(16'h0010), .off_lvl_in(16'h0010),
    .spike_in(16'h0010), .interval_out(ival[1]), .valid_out(vld[1]),
    .sample_out(s1));
  ////////////////////////////////////////////////////////////////////////
  // clock, 100 ns period
  initial
  begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wrt(input logic p, input logic [7:0] c, input logic [15:0] d);
    page = p;
    cmd = c;
    wdata = d;
    wr = 1'h1;
    cyc(1);
    wr = 1'h0;
    cyc(1);
  endtask
  task automatic rdq(input logic p, input logic [7:0] c, input logic [15:0] e);
    page = p;
    cmd = c;
    rd = 1'h1;
    exq.push_back(e);
    cyc(1);
    rd = 1'h0;
    cyc(1);
  endtask
  task automatic look(input logic [1:0] ee, eo, eu);
    chk({en, oc_f, uc_f, alert_n}, {ee, eo, eu, ~|{eo, eu}});
  endtask
  task automatic clear_all;
    clr = 1'h1;
    cyc(1);
    clr = 1'h0;
    cyc(2);
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // read results land on the same edge that samples the read
  always @(posedge clk)
  begin
    pend = rd;
    #1;
    if (pend)
      chk(rdata, exq.pop_front());
  end
  // watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge clk);
    failures++;
    end_sim;
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    rv = $urandom(32'hCEC3);
    {page, wr, rd, clr, cmd, wdata} = '0;
    {on_cmd, other, peak, uc, up, on0, off0, spk} = '0;
    rst = 1'h1;
    cyc(4);
    rst = 1'h0;
    for (int p = 0; p < 2; p++)
    begin
      rdq(p[0], CMD_OC_RESP, 16'h0080);
      rdq(p[0], CMD_UC_RESP, 16'h0080);
      rdq(p[0], CMD_AVG_OC_LIM, 16'hDA00);
    end
    rv = $urandom;
    wrt(1'h1, CMD_UC_RESP, {8'h00, rv[7:3], 3'h0});
    wrt(1'h1, CMD_AVG_OC_LIM, {5'h1C, 1'h0, rv[25:16]});
    rdq(1'h1, CMD_UC_RESP, {8'h00, rv[7:3], 3'h0});
    rdq(1'h1, CMD_AVG_OC_LIM, {5'h1C, 1'h0, rv[25:16]});
    rdq(1'h0, CMD_UC_RESP, 16'h0080);
    rdq(1'h0, 8'hE4, 16'h0000);
    wrt(1'h1, CMD_UC_RESP, 16'h0080);
    wrt(1'h1, CMD_AVG_OC_LIM, 16'hDA00);
    on0 = 16'h00A0;
    off0 = 16'h00A0;
    on_cmd = 2'h3;
    cyc(3);
    look(2'h3, 2'h0, 2'h0);
    peak[0] = 1'h1;
    cyc(1);
    look(2'h2, 2'h1, 2'h0);
    cyc(3 * RC);
    look(2'h2, 2'h1, 2'h0);
    peak[0] = 1'h0;
    clear_all;
    look(2'h3, 2'h0, 2'h0);
    for (int k = 0; k < 5; k++)
    begin
      wrt(1'h0, CMD_OC_RESP, {8'h00, bad[k]});
      peak[0] = 1'h1;
      cyc(1);
      peak[0] = 1'h0;
      cyc(2 * RC);
      look(2'h2, 2'h1, 2'h0);
      clear_all;
    end
    wrt(1'h0, CMD_OC_RESP, 16'h0080);
    wrt(1'h0, CMD_UC_RESP, 16'h00B8);
    uc[0] = 1'h1;
    cyc(1);
    look(2'h2, 2'h0, 2'h1);
    for (int k = 0; k < 2; k++)
    begin
      for (n = 0; en[0] !== 1'h1 && n < RC + 5; n++)
        cyc(1);
      chk(16'(n >= RC && n <= RC + 1), 16'h1);
      cyc(1);
    end
    on_cmd[0] = 1'h0;
    cyc(2 * RC);
    on_cmd[0] = 1'h1;
    cyc(2 * RC);
    look(2'h2, 2'h0, 2'h1);
    clear_all;
    other[0] = 1'h1;
    cyc(2 * RC);
    look(2'h2, 2'h0, 2'h1);
    {uc[0], other[0]} = 2'h0;
    clear_all;
    look(2'h3, 2'h0, 2'h0);
    wrt(1'h0, CMD_UC_RESP, 16'h0080);
    spk = 16'h03E8;
    cyc(100);
    look(2'h3, 2'h0, 2'h0);
    off0 = 16'h0140;
    cyc(80);
    look(2'h2, 2'h1, 2'h0);
    off0 = 16'h00A0;
    up[0] = 1'h1;
    cyc(40);
    clear_all;
    off0 = 16'h0140;
    cyc(100);
    look(2'h3, 2'h0, 2'h0);
    on0 = 16'h0140;
    cyc(80);
    look(2'h2, 2'h1, 2'h0);
    end_sim;
  end
endmodule // tb_top
